// [logic/adc_seq_map.svh]
// Constants for the converter sequencer control block.
`ifndef ADC_SEQ_MAP_SVH
`define ADC_SEQ_MAP_SVH
`define CLK_FREQ_MHZ       40
`define STAB_TIME_NS       1000
`define STAB_CYCLES        ((`STAB_TIME_NS * `CLK_FREQ_MHZ + 999) / 1000)
`define CONV_MIN_NS        3100
`define CONV_MAX_NS        15500
`define CONV_MIN_CYCLES    ((`CONV_MIN_NS * `CLK_FREQ_MHZ + 999) / 1000)
`define CONV_MAX_CYCLES    ((`CONV_MAX_NS * `CLK_FREQ_MHZ) / 1000)
`define NUM_CHANNELS       12
`define RESULT_WIDTH       10
`endif

// [logic/adc_seq_pkg.sv]
// Types shared by the converter sequencer control block.
package adc_seq_pkg;
    typedef enum logic [2:0] {
        ST_OFF,
        ST_STAB,
        ST_WAIT_TRIG,
        ST_CONVERT,
        ST_FINISH
    } seq_state_t;
endpackage : adc_seq_pkg

// [logic/adc_conv_timer.sv]
// Conversion timer producing a done pulse after a programmable cycle count.
`timescale 1ns/100ps
`include "adc_seq_map.svh"
module adc_conv_timer #(
    parameter int CW = 10
) (
    input  wire logic          clk,       // System clock.
    input  wire logic          reset,     // Synchronous reset.
    input  wire logic          start,     // Restart the count from zero.
    input  wire logic          run,       // Count while high.
    input  wire logic [CW-1:0] length,    // Cycles per conversion.
    output logic               done       // One-cycle end pulse.
);
    logic [CW-1:0] count_reg;
    logic [CW-1:0] count_next;
    logic          done_next;
    logic          done_reg;

    always_comb begin
        count_next = count_reg;
        done_next  = 1'b0;
        if (start || !run) begin
            count_next = '0;
        end else if (count_reg + CW'(1) >= length) begin
            count_next = '0;
            done_next  = 1'b1;
        end else begin
            count_next = count_reg + CW'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            count_reg <= '0;
            done_reg  <= 1'b0;
        end else begin
            count_reg <= count_next;
            done_reg  <= done_next;
        end
    end

    assign done = done_reg;
endmodule : adc_conv_timer

// [logic/adc_sequencer_control.sv]
// Control and result logic of a multi-channel successive approximation ADC.
`timescale 1ns/100ps
`include "adc_seq_map.svh"
module adc_sequencer_control #(
    parameter int NCH  = `NUM_CHANNELS,
    parameter int RW   = `RESULT_WIDTH,
    parameter int STAB = `STAB_CYCLES
) (
    input  wire logic            clk,          // 40 MHz clock.
    input  wire logic            reset,        // Synchronous active high.
    input  wire logic            converterEnableBit, // Converter enable.
    input  wire logic            hwTriggerMode, // 1: hardware trigger mode.
    input  wire logic            scanMode,     // 1: scan, 0: select mode.
    input  wire logic [3:0]      channelSelect, // Selected or last channel.
    input  wire logic            compareEnable, // Compare mode enabled.
    input  wire logic            compareConditionBit, // 1: ge, 0: lt.
    input  wire logic [7:0]      compareThreshold, // Threshold byte.
    input  wire logic [9:0]      convCycles,   // Cycles per conversion.
    input  wire logic            regWrite,     // Write to mode/chan/compare.
    input  wire logic            hwTrigger,    // Hardware trigger pulse.
    input  wire logic [RW-1:0]   sarResult,    // Analog core result.
    input  wire logic [3:0]      readChannel,  // Result read index.
    output logic [RW-1:0]        conversionResult, // Result of readChannel.
    output logic [7:0]           resultHighByte, // High byte of that result.
    output logic [3:0]           activeChannel, // Channel being converted.
    output logic                 converterPowered, // Analog power on.
    output logic                 conversionActiveFlag, // Busy flag.
    output logic                 conversionDoneIrq // Done pulse.
);
    adc_seq_pkg::seq_state_t state_reg, state_next;
    logic [15:0]   stab_reg, stab_next;
    logic [3:0]    chan_reg, chan_next;
    logic          irq_reg, irq_next;
    logic          enPrev_reg;
    logic [RW-1:0] results_reg [NCH];
    logic          convDone;
    logic          convStart;
    logic          storeNow;
    logic          cmpHit;
    logic          convRun;

    function automatic logic compare_ok(input logic [7:0] hi,
                                        input logic [7:0] th,
                                        input logic       ge);
        compare_ok = ge ? (hi >= th) : (hi < th);
    endfunction : compare_ok

    adc_conv_timer #(.CW(10)) u_timer (
        .clk    (clk),
        .reset  (reset),
        .start  (convStart),
        .run    (convRun),
        .length (convCycles),
        .done   (convDone)
    );

    // A new conversion starts on entry to convert or on restart.
    assign convStart = (state_reg != adc_seq_pkg::ST_CONVERT) ||
                       regWrite;
    // The timer stops when disabled, so no late done pulse follows a stop.
    assign convRun = (state_reg == adc_seq_pkg::ST_CONVERT) &&
                     converterEnableBit;
    // The compare looks at the high byte of the word that would be stored.
    assign cmpHit = compare_ok(sarResult[RW-1 -: 8], compareThreshold,
                               compareConditionBit);

    // Sequencer: off, stabilise, wait for a trigger, convert, then finish.
    always_comb begin
        state_next = state_reg;
        stab_next  = stab_reg;
        chan_next  = chan_reg;
        irq_next   = 1'b0;
        storeNow   = 1'b0;
        case (state_reg)
            adc_seq_pkg::ST_OFF: begin
                stab_next = '0;
                if (converterEnableBit && !enPrev_reg) begin
                    state_next = adc_seq_pkg::ST_STAB;
                end
            end
            adc_seq_pkg::ST_STAB: begin
                stab_next = stab_reg + 16'h0001;
                if (stab_reg + 16'h0001 >= 16'(STAB)) begin
                    state_next = hwTriggerMode ? adc_seq_pkg::ST_WAIT_TRIG
                                               : adc_seq_pkg::ST_CONVERT;
                    chan_next  = scanMode ? 4'h0 : channelSelect;
                end
            end
            adc_seq_pkg::ST_WAIT_TRIG: begin
                if (hwTrigger) begin
                    state_next = adc_seq_pkg::ST_CONVERT;
                    chan_next  = scanMode ? 4'h0 : channelSelect;
                end
            end
            adc_seq_pkg::ST_CONVERT: begin
                if (regWrite) begin
                    chan_next = scanMode ? 4'h0 : channelSelect;
                    if (hwTriggerMode) begin
                        state_next = adc_seq_pkg::ST_WAIT_TRIG;
                    end // else the timer restarts in place.
                end else if (convDone) begin
                    state_next = adc_seq_pkg::ST_FINISH;
                end
            end
            adc_seq_pkg::ST_FINISH: begin
                if (!compareEnable) begin
                    storeNow = 1'b1;
                    irq_next = !scanMode || chan_reg == channelSelect;
                end else if (!scanMode) begin
                    storeNow = cmpHit;
                    irq_next = cmpHit;
                end else begin
                    storeNow = 1'b1;
                    irq_next = (chan_reg == 4'h0) && cmpHit;
                end
                if (scanMode && chan_reg != channelSelect) begin
                    chan_next  = chan_reg + 4'h1;
                    state_next = adc_seq_pkg::ST_CONVERT;
                end else begin
                    chan_next  = scanMode ? 4'h0 : channelSelect;
                    state_next = hwTriggerMode ? adc_seq_pkg::ST_WAIT_TRIG
                                               : adc_seq_pkg::ST_CONVERT;
                end
            end
            default: state_next = adc_seq_pkg::ST_OFF;
        endcase
        if (!converterEnableBit) begin
            state_next = adc_seq_pkg::ST_OFF;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state_reg  <= adc_seq_pkg::ST_OFF;
            stab_reg   <= '0;
            chan_reg   <= '0;
            irq_reg    <= 1'b0;
            enPrev_reg <= 1'b0;
        end else begin
            state_reg  <= state_next;
            stab_reg   <= stab_next;
            chan_reg   <= chan_next;
            irq_reg    <= irq_next;
            enPrev_reg <= converterEnableBit;
        end
    end

    // Result store; a stored word may be stale after a restart.
    always_ff @(posedge clk) begin
        if (reset) begin
            for (int i = 0; i < NCH; i++) begin
                results_reg[i] <= '0;
            end
        end else if (storeNow && chan_reg < 4'(NCH)) begin
            results_reg[chan_reg] <= sarResult;
        end
    end

    assign conversionResult = (readChannel < 4'(NCH)) ?
                              results_reg[readChannel] : '0;
    assign resultHighByte   = conversionResult[RW-1 -: 8];
    assign activeChannel    = chan_reg;
    assign converterPowered = (state_reg != adc_seq_pkg::ST_OFF);
    // The busy flag covers the finish cycle so that a store never looks idle.
    assign conversionActiveFlag =
        (state_reg == adc_seq_pkg::ST_CONVERT) ||
        (state_reg == adc_seq_pkg::ST_FINISH);
    assign conversionDoneIrq = irq_reg;

    // Checks on the rules that this block carries out.
    chk_disable_powers_down: assert property (@(posedge clk)
        disable iff (reset) !converterEnableBit |=> !converterPowered)
        else $error("Converter still powered after disable.");
    chk_stab_before_conv: assert property (@(posedge clk)
        disable iff (reset) $rose(converterEnableBit) && !enPrev_reg |=>
        !conversionActiveFlag [*2])
        else $error("Conversion began during stabilization.");
    chk_select_irq_cause: assert property (@(posedge clk)
        disable iff (reset) state_reg == adc_seq_pkg::ST_FINISH &&
        compareEnable && !scanMode && !cmpHit |=> !conversionDoneIrq)
        else $error("Select mode interrupt without compare match.");
    chk_select_irq_hit: assert property (@(posedge clk)
        disable iff (reset) state_reg == adc_seq_pkg::ST_FINISH &&
        compareEnable && !scanMode && cmpHit && converterEnableBit
        |=> conversionDoneIrq)
        else $error("Select mode match gave no interrupt.");
    chk_scan_irq_first: assert property (@(posedge clk)
        disable iff (reset) state_reg == adc_seq_pkg::ST_FINISH &&
        compareEnable && scanMode && chan_reg != 4'h0
        |=> !conversionDoneIrq)
        else $error("Scan interrupt from a later channel.");
    chk_hw_abort_wait: assert property (@(posedge clk)
        disable iff (reset) state_reg == adc_seq_pkg::ST_CONVERT &&
        regWrite && hwTriggerMode && converterEnableBit
        |=> state_reg == adc_seq_pkg::ST_WAIT_TRIG)
        else $error("Hardware mode write did not return to trigger wait.");
    chk_sw_restart: assert property (@(posedge clk)
        disable iff (reset) state_reg == adc_seq_pkg::ST_CONVERT &&
        regWrite && !hwTriggerMode && converterEnableBit
        |=> conversionActiveFlag && !convDone)
        else $error("Software mode write did not restart conversion.");
    chk_flag_tracks: assert property (@(posedge clk)
        disable iff (reset) convDone |-> conversionActiveFlag)
        else $error("Conversion ended with busy flag clear.");
    chk_enable_powers_up: assert property (@(posedge clk)
        disable iff (reset) $rose(converterEnableBit) |=> converterPowered)
        else $error("Enable did not start stabilization.");
    chk_irq_one_cycle: assert property (@(posedge clk)
        disable iff (reset) conversionDoneIrq |=> !conversionDoneIrq)
        else $error("Done interrupt stood longer than one cycle.");
    chk_off_not_busy: assert property (@(posedge clk)
        disable iff (reset) !converterEnableBit |=> !conversionActiveFlag)
        else $error("Busy flag still set after disable.");

    // Cover points for the main scenarios.
    cov_select_irq: cover property (@(posedge clk) disable iff (reset)
        conversionDoneIrq && !scanMode);
    cov_scan_irq: cover property (@(posedge clk) disable iff (reset)
        conversionDoneIrq && scanMode);
    cov_restart: cover property (@(posedge clk) disable iff (reset)
        conversionActiveFlag && regWrite);
    cov_hw_abort: cover property (@(posedge clk) disable iff (reset)
        state_reg == adc_seq_pkg::ST_CONVERT && regWrite && hwTriggerMode);
    cov_stab_exit: cover property (@(posedge clk) disable iff (reset)
        state_reg == adc_seq_pkg::ST_STAB ##1 conversionActiveFlag);
endmodule : adc_sequencer_control

// [bench/adc_sequencer_control_tb.sv]
// Self-checking testbench for the converter sequencer control block.
`timescale 1ns/100ps
`include "adc_seq_map.svh"
`define CHK(got, exp) begin numChecks++; if ((got) !== (exp)) begin \
    errors++; $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, \
    exp); end end
module adc_sequencer_control_tb;
    localparam int STAB = 4;
    // Shortest legal conversion; it stays fixed while the converter runs.
    localparam int CONV = `CONV_MIN_CYCLES;
    localparam int LIM  = CONV + 20;
    logic       clk = 1'b0, reset = 1'b1, enable = 1'b0, hwMode = 1'b0;
    logic       scanMode = 1'b0, cmpEn = 1'b0, cmpCond = 1'b0;
    logic       regWrite = 1'b0, hwTrigger = 1'b0;
    logic [3:0] chanSel = 4'h0, readChannel = 4'h0, activeChannel;
    logic [7:0] threshold = 8'h00, resultHighByte;
    logic [9:0] convCycles = 10'(CONV), sarResult = 10'h000, convResult;
    logic       powered, activeFlag, doneIrq;
    logic [9:0] prev;
    int         errors = 0, numChecks = 0, cycles = 0, n;
    logic [7:0] thrTab [4] = '{8'ha9, 8'haa, 8'haa, 8'ha9};
    logic       cndTab [4] = '{1'b1, 1'b1, 1'b0, 1'b0};
    logic       expTab [4] = '{1'b1, 1'b0, 1'b1, 1'b0};

    adc_sequencer_control #(.STAB(STAB)) dut_u (
        .clk                 (clk),
        .reset               (reset),
        .converterEnableBit  (enable),
        .hwTriggerMode       (hwMode),
        .scanMode            (scanMode),
        .channelSelect       (chanSel),
        .compareEnable       (cmpEn),
        .compareConditionBit (cmpCond),
        .compareThreshold    (threshold),
        .convCycles          (convCycles),
        .regWrite            (regWrite),
        .hwTrigger           (hwTrigger),
        .sarResult           (sarResult),
        .readChannel         (readChannel),
        .conversionResult    (convResult),
        .resultHighByte      (resultHighByte),
        .activeChannel       (activeChannel),
        .converterPowered    (powered),
        .conversionActiveFlag(activeFlag),
        .conversionDoneIrq   (doneIrq)
    );

    initial begin
        forever #12.5 clk = ~clk;
    end

    task automatic results;
        if (errors == 0 && numChecks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : results

    always @(posedge clk) begin
        cycles++;
        // About 2250 cycles are needed; the ceiling leaves ample room.
        if (cycles == 5000) begin
            errors++;
            results();
        end
    end

    // Sets the mode, channel and compare settings and the analog result, and announces them with one write strobe.
    task automatic cfg(input logic hwm, scn, input logic [3:0] ch,
                       input logic ce, cnd, input logic [7:0] thr,
                       input logic [9:0] sar);
        @(posedge clk);
        {hwMode, scanMode, chanSel, cmpEn} <= {hwm, scn, ch, ce};
        {cmpCond, threshold, sarResult} <= {cnd, thr, sar};
        regWrite <= 1'b1;
        @(posedge clk);
        regWrite <= 1'b0;
    endtask : cfg

    task automatic waitIrq(input int lim);
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (doneIrq !== 1'b1 && n < lim);
    endtask : waitIrq

    task automatic rd(input logic [3:0] ch, input logic [9:0] exp);
        @(posedge clk);
        readChannel <= ch;
        @(negedge clk);
        `CHK(convResult, exp)
        `CHK(resultHighByte, exp[9:2])
    endtask : rd

    task automatic trig;
        @(posedge clk);
        hwTrigger <= 1'b1;
        @(posedge clk);
        hwTrigger <= 1'b0;
    endtask : trig

    initial begin
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        // Settings are made while disabled; reserved mode bits are no ports.
        cfg(1'b0, 1'b0, 4'h3, 1'b0, 1'b0, 8'h00, 10'h2a5);
        @(posedge clk);
        enable <= 1'b1;
        repeat (STAB) begin
            @(negedge clk);
            `CHK(activeFlag, 1'b0)
        end
        `CHK(powered, 1'b1)
        repeat (4) @(negedge clk);
        `CHK(activeFlag, 1'b1)
        waitIrq(LIM);
        `CHK(doneIrq, 1'b1)
        // The bench clock is the main clock, so result reads are allowed.
        rd(4'h3, 10'h2a5);
        prev = 10'h2a5;
        for (int i = 0; i < 4; i++) begin
            cfg(1'b0, 1'b0, 4'h3, 1'b1, cndTab[i], thrTab[i],
                10'h2a4 + 10'(i));
            waitIrq(LIM);
            `CHK(doneIrq, expTab[i])
            if (expTab[i]) prev = 10'h2a4 + 10'(i);
            rd(4'h3, prev);
        end
        cfg(1'b0, 1'b0, 4'h3, 1'b0, 1'b0, 8'h00, 10'h0f0);
        waitIrq(LIM);
        repeat (10) @(posedge clk);
        cfg(1'b0, 1'b0, 4'h3, 1'b0, 1'b0, 8'h00, 10'h0f0);
        waitIrq(LIM);
        `CHK(doneIrq, 1'b1)
        `CHK(n >= CONV, 1'b1)
        cfg(1'b1, 1'b0, 4'h3, 1'b0, 1'b0, 8'h00, 10'h111);
        waitIrq(LIM);
        `CHK(doneIrq, 1'b0)
        trig();
        repeat (3) @(negedge clk);
        `CHK(activeFlag, 1'b1)
        cfg(1'b1, 1'b0, 4'h3, 1'b0, 1'b0, 8'h00, 10'h111);
        waitIrq(LIM);
        `CHK(doneIrq, 1'b0)
        `CHK(activeFlag, 1'b0)
        trig();
        waitIrq(LIM);
        `CHK(doneIrq, 1'b1)
        rd(4'h3, 10'h111);
        // Trigger wait is left by a trigger or a disable; the disable here lets scan start afresh.
        @(posedge clk);
        enable <= 1'b0;
        repeat (2) @(negedge clk);
        `CHK(powered, 1'b0)
        cfg(1'b0, 1'b1, 4'h2, 1'b1, 1'b1, 8'hff, 10'h155);
        @(posedge clk);
        enable <= 1'b1;
        waitIrq(3 * CONV + 40 + STAB);
        `CHK(doneIrq, 1'b0)
        for (int c = 0; c < 3; c++) rd(4'(c), 10'h155);
        rd(4'h3, 10'h111);
        cfg(1'b0, 1'b1, 4'h2, 1'b1, 1'b1, 8'h00, 10'h156);
        waitIrq(LIM);
        `CHK(doneIrq, 1'b1)
        `CHK(activeChannel, 4'h1)
        waitIrq(2 * CONV + 40);
        `CHK(doneIrq, 1'b0)
        rd(4'h2, 10'h156);
        @(posedge clk);
        enable <= 1'b0;
        repeat (2) @(negedge clk);
        `CHK(powered, 1'b0)
        `CHK(activeFlag, 1'b0)
        waitIrq(20);
        `CHK(doneIrq, 1'b0)
        results();
    end
endmodule : adc_sequencer_control_tb
